// File: rtl/qes_pkg.sv
// shared constants and types for the quadrature edge service block
package qes_pkg;
	// core clock
	localparam int CLK_PERIOD_NS   = 20;
	// longest time one queued edge may take to service, in ns
	localparam int SVC_TIME_NS     = 14000;
	// longest time rounds down to whole cycles
	localparam int SVC_CYC         = SVC_TIME_NS / CLK_PERIOD_NS;
	// aggregate edge budgets, edges per second
	localparam int EDGE_RATE_FULL  = 70000;
	localparam int EDGE_RATE_STRM  = 20000;
	// one stream slot holds exactly one edge service while streaming
	localparam int STRM_PERIOD_NS  = 1000000000 / EDGE_RATE_STRM;
	localparam int STRM_PERIOD_CYC = STRM_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STRM_BUSY_CYC   = STRM_PERIOD_CYC - SVC_CYC;
	// slot of the full budget; the service time must fit inside it
	localparam int EDGE_SLOT_NS    = 1000000000 / EDGE_RATE_FULL;
	localparam bit SVC_FITS        = (SVC_TIME_NS <= EDGE_SLOT_NS);
	// channels and synchronised level layout
	localparam int NUM_CH          = 2;
	localparam int CH_W            = 1;
	localparam int LVL_A           = 0;
	localparam int LVL_B           = 1;
	localparam int LVL_IDX         = 2;
	localparam int LVL_W           = 3;
	// counter widths and reset values
	localparam int CNT_W           = 32;
	localparam int ERR_W           = 32;
	localparam logic [1:0] AB_RST  = 2'h0;
	// index control codes
	localparam logic [1:0] IDX_OFF  = 2'h0;
	localparam logic [1:0] IDX_ON   = 2'h1;
	localparam logic [1:0] IDX_ONCE = 2'h3;
	// scheduler states
	typedef enum logic [0:0] {SCH_IDLE, SCH_RUN} qes_sch_e;
endpackage

// File: rtl/qes_link_if.sv
// link between the synchroniser, the edge scheduler and the top
`timescale 1ns/1ps
interface qes_link_if #(
	parameter int NCH = 2,
	parameter int CHW = 1,
	parameter int LW  = 3
);
	logic [LW-1:0]  lvl;
	logic [NCH-1:0] edgeHit;
	logic [NCH-1:0] take;
	logic           hold;
	logic           done;
	logic           inSvc;
	logic [CHW-1:0] svcCh;

	modport syn (output lvl, output edgeHit);
	modport sch (input edgeHit, input hold, output take, output done,
		output inSvc, output svcCh);
	modport top (input lvl, input edgeHit, input take, input done, input inSvc,
		input svcCh, output hold);
endinterface

// File: rtl/qes_sync.sv
// two-stage synchroniser for phase and index lines, edge detector for the phase lines only
`timescale 1ns/1ps
module qes_sync #(
	parameter int LW  = 3,
	parameter int NCH = 2
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst_n,
	// raw lines
	input  wire logic [LW-1:0] rawLine,
	// toward scheduler and top
	qes_link_if.syn            lk
);
	logic [LW-1:0] meta_r;
	logic [LW-1:0] stab_r;
	logic [LW-1:0] last_r;

	// per line: meta feeds only stab; edges compare stab and last
	genvar i;
	generate
		for (i = 0; i < LW; i++)
		begin : g_line
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
				begin
					meta_r[i] <= 1'b0;
					stab_r[i] <= 1'b0;
					last_r[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= rawLine[i];
					stab_r[i] <= meta_r[i];
					last_r[i] <= stab_r[i];
				end
			end
		end
		// rising and falling edges on each phase both count
		for (i = 0; i < NCH; i++)
		begin : g_edge
			assign lk.edgeHit[i] = stab_r[i] ^ last_r[i];
		end
	endgenerate

	assign lk.lvl = stab_r;
endmodule

// File: rtl/qes_sched.sv
// pending flags and one-at-a-time edge service timer
`timescale 1ns/1ps
module qes_sched #(
	parameter int NCH     = 2,
	parameter int CHW     = 1,
	parameter int SVC_CYC = 700
) (
	// clock and reset
	input  wire logic           mclk,
	input  wire logic           rst_n,
	// feature enable
	input  wire logic           en,
	// link and flag view
	qes_link_if.sch             lk,
	output logic      [NCH-1:0] pending
);
	qes_pkg::qes_sch_e state_r;
	logic [NCH-1:0] pend_r;
	logic [CHW-1:0] ch_r;
	logic [15:0]    cnt_r;
	logic [NCH-1:0] svcMask;
	logic [NCH-1:0] clrMask;
	logic [CHW-1:0] pickCh;
	logic           running;
	logic           lastCyc;

	// lowest numbered pending channel wins
	function automatic logic [CHW-1:0] pickLow(input logic [NCH-1:0] p);
		logic [CHW-1:0] r;
		r = '0;
		for (int k = NCH - 1; k >= 0; k--)
			if (p[k])
				r = CHW'(k);
		return r;
	endfunction

	// edges on the channel under service are dropped
	assign running  = (state_r == qes_pkg::SCH_RUN);
	assign svcMask  = running ? (NCH'(1) << ch_r) : '0;
	assign lk.take  = lk.edgeHit & ~svcMask & {NCH{en}};
	assign lastCyc  = (cnt_r == 16'(SVC_CYC - 1));
	assign lk.done  = running && !lk.hold && lastCyc;
	assign clrMask  = lk.done ? svcMask : '0;
	assign pickCh   = pickLow(pend_r);
	assign lk.inSvc = running;
	assign lk.svcCh = ch_r;
	assign pending  = pend_r;

	// a repeat edge on a waiting channel just keeps its one flag
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pend_r <= '0;
		else
			pend_r <= (pend_r & ~clrMask) | lk.take;
	end

	// service runs to its end before another starts; stream hold pauses it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_r <= qes_pkg::SCH_IDLE;
			ch_r    <= '0;
			cnt_r   <= 16'h0000;
		end
		else
		begin
			case (state_r)
				qes_pkg::SCH_IDLE:
				begin
					if (|pend_r)
					begin
						state_r <= qes_pkg::SCH_RUN;
						ch_r    <= pickCh;
						cnt_r   <= 16'h0000;
					end
				end
				qes_pkg::SCH_RUN:
				begin
					if (lk.done)
						state_r <= qes_pkg::SCH_IDLE;
					else if (!lk.hold)
						cnt_r <= cnt_r + 16'h0001;
				end
				default:
					state_r <= qes_pkg::SCH_IDLE;
			endcase
		end
	end
endmodule

// File: rtl/qes_top.sv
// quadrature edge service: 4x decoder behind a serialised edge scheduler
// Operation
// - count changes by one on every serviced rising and falling edge of both phases that decodes as a single step
// - up to 70k edges per second in aggregate are serviced without loss
// - while streaming, the guaranteed aggregate budget drops to 20k edges per second
// - every edge of either polarity is queued for service while enabled, except on the channel being serviced
// - one queued edge takes no more than 14 us to service
// - an applicable edge sets that channel's pending flag
// - a started service runs to completion before any other starts
// - streaming service has priority and pre-empts edge service
// - completing a service clears that channel's pending flag
// - an edge on the channel being serviced is discarded
// - a second edge on a still-pending channel replaces the earlier one
// - a new edge during the second channel's own service is discarded
// - even line is phase A, odd line is phase B
// - signed two's complement position and a separate decode error count
// - index control 1 clears on index high, 3 clears once, 0 off
// - read-with-clear returns the count, zeroes it and re-arms one-shot index
`timescale 1ns/1ps
module qes_top #(
	parameter int CNT_W = qes_pkg::CNT_W,
	parameter int ERR_W = qes_pkg::ERR_W
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// encoder lines
	input  wire logic             phaseEven,
	input  wire logic             phaseOdd,
	input  wire logic             indexLine,
	// control
	input  wire logic             featEnable,
	input  wire logic [1:0]       indexMode,
	input  wire logic             streamOn,
	input  wire logic             readReq,
	input  wire logic             readClrReq,
	// results
	output logic signed [CNT_W-1:0] posCount,
	output logic [ERR_W-1:0]      errCount,
	output logic signed [CNT_W-1:0] readData,
	output logic                  readValid,
	// service view
	output logic [qes_pkg::NUM_CH-1:0] pending,
	output logic                  svcBusy,
	output logic                  streamHold
);
	localparam int NCH = qes_pkg::NUM_CH;
	localparam int CHW = qes_pkg::CH_W;
	localparam int LW  = qes_pkg::LVL_W;

	qes_link_if #(.NCH(NCH), .CHW(CHW), .LW(LW)) lk ();

	logic [LW-1:0]         rawLine;
	logic [LW-1:0]         snap_r [NCH];
	logic [LW-1:0]         cur;
	logic [1:0]            prevAb_r;
	logic [1:0]            newAb;
	logic [1:0]            fwdAb;
	logic [1:0]            bwdAb;
	logic                  stepUp;
	logic                  stepDn;
	logic                  stepErr;
	logic                  idxArmed;
	logic                  idxHit;
	logic                  armed_r;
	logic                  enPrev_r;
	logic                  enRise;
	logic                  rearm;
	logic [15:0]           strmCnt_r;
	logic                  strmWrap;
	logic signed [CNT_W-1:0] pos_r;
	logic signed [CNT_W-1:0] posBase;
	logic signed [CNT_W-1:0] pos_nxt;
	logic [ERR_W-1:0]      err_r;
	logic signed [CNT_W-1:0] rdData_r;
	logic                  rdValid_r;

	// even line is phase A, odd line is phase B
	assign rawLine[qes_pkg::LVL_A]   = phaseEven;
	assign rawLine[qes_pkg::LVL_B]   = phaseOdd;
	assign rawLine[qes_pkg::LVL_IDX] = indexLine;

	qes_sync #(
		.LW  (LW),
		.NCH (NCH)
	) u_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.rawLine (rawLine),
		.lk      (lk)
	);

	qes_sched #(
		.NCH     (NCH),
		.CHW     (CHW),
		.SVC_CYC (qes_pkg::SVC_CYC)
	) u_sched (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.en      (featEnable),
		.lk      (lk),
		.pending (pending)
	);

	// stream task owns the first part of each slot, leaving one service time
	assign strmWrap   = (strmCnt_r == 16'(qes_pkg::STRM_PERIOD_CYC - 1));
	assign lk.hold    = streamOn && (strmCnt_r < 16'(qes_pkg::STRM_BUSY_CYC));
	assign streamHold = lk.hold;

	// slot divider; idle at zero when streaming is off
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !streamOn)
			strmCnt_r <= 16'h0000;
		else if (strmWrap)
			strmCnt_r <= 16'h0000;
		else
			strmCnt_r <= strmCnt_r + 16'h0001;
	end

	// each taken edge overwrites its channel's snapshot, so only the latest survives
	genvar c;
	generate
		for (c = 0; c < NCH; c++)
		begin : g_snap
			always_ff @(posedge mclk)
			begin
				if (!rst_n)
					snap_r[c] <= '0;
				else if (lk.take[c])
					snap_r[c] <= lk.lvl;
			end
		end
	endgenerate

	// decode the finished channel's snapshot against the last decoded state
	assign cur     = snap_r[lk.svcCh];
	assign newAb   = {cur[qes_pkg::LVL_B], cur[qes_pkg::LVL_A]};
	assign fwdAb   = {~prevAb_r[0], prevAb_r[1]}; // 00,10,11,01 order forward
	assign bwdAb   = {prevAb_r[0], ~prevAb_r[1]};
	assign stepUp  = lk.done && (newAb == fwdAb);
	assign stepDn  = lk.done && (newAb == bwdAb);
	assign stepErr = lk.done && (newAb == ~prevAb_r);

	// index clears only at a serviced phase edge with index high
	assign idxArmed = (indexMode == qes_pkg::IDX_ON) ||
		((indexMode == qes_pkg::IDX_ONCE) && armed_r);
	assign idxHit   = lk.done && cur[qes_pkg::LVL_IDX] && idxArmed;

	// re-arm on read-with-clear or on feature enable
	assign enRise = featEnable && !enPrev_r;
	assign rearm  = readClrReq || enRise;

	// read-with-clear zeroes first, then this cycle's edge applies
	assign posBase = readClrReq ? '0 : pos_r;
	always_comb
	begin
		pos_nxt = posBase;
		if (idxHit)
			pos_nxt = '0;
		else if (stepUp)
			pos_nxt = posBase + CNT_W'(1);
		else if (stepDn)
			pos_nxt = posBase - CNT_W'(1);
	end

	// signed position, wraps in two's complement
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pos_r <= '0;
		else
			pos_r <= pos_nxt;
	end

	// decode errors are counted apart from the position
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			err_r <= '0;
		else if (stepErr)
			err_r <= err_r + ERR_W'(1);
	end

	// last decoded phase state; follows the lines while disabled to avoid a false step
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			prevAb_r <= qes_pkg::AB_RST;
		else if (!featEnable)
			prevAb_r <= {lk.lvl[qes_pkg::LVL_B], lk.lvl[qes_pkg::LVL_A]};
		else if (lk.done)
			prevAb_r <= newAb;
	end

	// one-shot arm: a re-arm in the same cycle as a clear wins
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			armed_r  <= 1'b1;
			enPrev_r <= 1'b0;
		end
		else
		begin
			enPrev_r <= featEnable;
			if (rearm)
				armed_r <= 1'b1;
			else if (idxHit && indexMode == qes_pkg::IDX_ONCE)
				armed_r <= 1'b0;
		end
	end

	// read capture returns the count as it stood before any clear
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rdData_r  <= '0;
			rdValid_r <= 1'b0;
		end
		else
		begin
			rdValid_r <= readReq || readClrReq;
			if (readReq || readClrReq)
				rdData_r <= pos_r;
		end
	end

	assign posCount  = pos_r;
	assign errCount  = err_r;
	assign readData  = rdData_r;
	assign readValid = rdValid_r;
	assign svcBusy   = lk.inSvc;
endmodule

// File: sim/qes_encoder.sv
// encoder model: two gray-coded phase lines and an index line
`timescale 1ns/1ps
module qes_encoder (
	// clock
	input	wire logic	mclk,
	// move command from the bench
	input	wire logic	stepReq,
	input	wire logic	stepBack,
	input	wire logic	jump,
	input	wire logic	idxHi,
	// encoder lines
	output	logic		phA,
	output	logic		phB,
	output	logic		idx
);
	logic [1:0]	pos_r = 2'h0;
	logic [1:0]	pos_nxt;
	// a jump skips one state so both lines flip together, a real encoder fault
	assign pos_nxt = pos_r + (jump ? 2'h2 : stepBack ? 2'h3 : 2'h1);
	// lines move just after the edge, never on it
	always @(posedge mclk)
	begin
		if (stepReq)
			pos_r <= #1 pos_nxt;
	end
	// forward order of {B,A} is 00,10,11,01; even line is phase A
	assign phA = pos_r[1];
	assign phB = pos_r[1] ^ pos_r[0];
	assign idx = idxHi;
endmodule

// File: sim/qes_top_asserts.sv
// concurrent checks on the quadrature edge service top ports
`timescale 1ns/1ps
module qes_top_asserts #(
	parameter int CNT_W = 32,
	parameter int ERR_W = 32
) (
	// clock and reset
	input	wire logic			mclk,
	input	wire logic			rst_n,
	// requests
	input	wire logic			readReq,
	input	wire logic			readClrReq,
	// results
	input	wire logic signed [CNT_W-1:0]	posCount,
	input	wire logic [ERR_W-1:0]		errCount,
	input	wire logic signed [CNT_W-1:0]	readData,
	input	wire logic			readValid,
	input	wire logic [1:0]		pending,
	input	wire logic			svcBusy,
	input	wire logic			streamHold
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int unsigned	svcCnt_r;
	// unheld cycles already spent on the running service
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !svcBusy)
			svcCnt_r <= 0;
		else if (!streamHold)
			svcCnt_r <= svcCnt_r + 1;
	end
	a_read_pulse: assert property ((readReq || readClrReq) |=> readValid)
		else $error("read request gave no valid pulse");
	a_valid_cause: assert property (!(readReq || readClrReq) |=> !readValid)
		else $error("valid pulse without a request");
	a_read_data: assert property ((readReq || readClrReq) |=> readData == $past(posCount))
		else $error("read data differs from count");
	a_clear_zero: assert property (readClrReq && !svcBusy |=> posCount == '0)
		else $error("count not zeroed by clear");
	a_svc_time: assert property (svcBusy |-> svcCnt_r < qes_pkg::SVC_CYC)
		else $error("edge service ran too long");
	a_busy_pend: assert property (svcBusy |-> pending != '0)
		else $error("service without a pending flag");
	a_hold_pause: assert property (streamHold && svcBusy |=> svcBusy)
		else $error("service finished inside a stream hold");
	a_count_cause: assert property ($changed(posCount) |-> $fell(svcBusy) || $past(readClrReq))
		else $error("count moved without a service");
	a_err_step: assert property ($changed(errCount) |-> $fell(svcBusy) && errCount == $past(errCount) + 1)
		else $error("error count moved wrongly");
endmodule
bind qes_top qes_top_asserts #(.CNT_W(CNT_W), .ERR_W(ERR_W)) u_chk (.mclk(mclk), .rst_n(rst_n),
	.readReq(readReq), .readClrReq(readClrReq), .posCount(posCount), .errCount(errCount),
	.readData(readData), .readValid(readValid), .pending(pending), .svcBusy(svcBusy),
	.streamHold(streamHold));

// File: sim/quadrature_edge_service_tb.sv
// self-checking bench for the quadrature edge service block
`timescale 1ns/1ps
module quadrature_edge_service_tb;
	logic			mclk = 1'b0;
	logic			rst_n = 1'b0;
	logic			featEnable = 1'b1;
	logic [1:0]		indexMode = 2'h0;
	logic			streamOn = 1'b0;
	logic			readReq = 1'b0;
	logic			readClrReq = 1'b0;
	logic			stepReq = 1'b0;
	logic			stepBack = 1'b0;
	logic			jump = 1'b0;
	logic			idxHi = 1'b0;
	logic			phA, phB, idx, readValid, svcBusy, streamHold;
	logic signed [31:0]	posCount, readData;
	logic [31:0]		errCount;
	logic [1:0]		pending;
	int			n_fail = 0;
	int			n_checks = 0;
	int			expPos = 0;
	int			expErr = 0;
	bit			armed = 1'b1;
	initial forever #10 mclk = ~mclk;
	qes_encoder u_enc (.mclk(mclk), .stepReq(stepReq), .stepBack(stepBack), .jump(jump),
		.idxHi(idxHi), .phA(phA), .phB(phB), .idx(idx));
	qes_top u_dut (.mclk(mclk), .rst_n(rst_n), .phaseEven(phA), .phaseOdd(phB),
		.indexLine(idx), .featEnable(featEnable), .indexMode(indexMode),
		.streamOn(streamOn), .readReq(readReq), .readClrReq(readClrReq),
		.posCount(posCount), .errCount(errCount), .readData(readData),
		.readValid(readValid), .pending(pending), .svcBusy(svcBusy),
		.streamHold(streamHold));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one encoder move, then a fixed gap
	task automatic step(input bit back, input bit jmp, input int gap);
		stepBack = back;
		jump = jmp;
		stepReq = 1'b1;
		tick(1);
		stepReq = 1'b0;
		tick(gap);
	endtask
	// bounded wait until every flag is serviced
	task automatic settle;
		int i;
		i = 0;
		tick(8);
		while ((svcBusy !== 1'b0 || pending !== 2'h0) && i < 8000)
		begin
			tick(1);
			i++;
		end
		if (i == 8000)
		begin
			n_fail++;
			test_done();
		end
	endtask
	// move, predict the count, wait and compare
	task automatic move(input bit back, input bit jmp);
		step(back, jmp, 1);
		if (jmp)
			expErr++;
		else if (idxHi && (indexMode == 2'h1 || (indexMode == 2'h3 && armed)))
		begin
			expPos = 0;
			if (indexMode == 2'h3)
				armed = 1'b0;
		end
		else
			expPos += back ? -1 : 1;
		settle();
		chk(posCount, expPos);
		chk(errCount, expErr);
	endtask
	// one read request; its answer stands the next cycle
	task automatic rd(input bit clr);
		readReq = !clr;
		readClrReq = clr;
		tick(1);
		readReq = 1'b0;
		readClrReq = 1'b0;
		chk(readValid, 1'b1);
		chk(readData, expPos);
		if (clr)
		begin
			expPos = 0;
			armed = 1'b1;
		end
	endtask
	initial
	begin
		void'($urandom(32'h5E27));
		tick(6);
		rst_n = 1'b1;
		chk({pending, svcBusy, streamHold, readValid}, 32'h0);
		chk(posCount, 32'h0);
		chk(errCount, 32'h0);
		repeat (20) move(1'($urandom), 1'b0);
		repeat (6) move(1'b1, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			step(1'b0, 1'b0, 714);
			expPos++;
		end
		settle();
		chk(posCount, expPos);
		move(1'b0, 1'b1);
		$display("walk done");
		featEnable = 1'b0;
		step(1'b0, 1'b0, 20);
		featEnable = 1'b1;
		armed = 1'b1;
		settle();
		chk(posCount, expPos);
		rd(1'b0);
		tick(1);
		rd(1'b1);
		tick(1);
		chk(readValid, 32'h0);
		chk(posCount, 32'h0);
		$display("read done");
		idxHi = 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			indexMode = 2'(m);
			repeat (2) move(1'b0, 1'b0);
		end
		rd(1'b1);
		move(1'b0, 1'b0);
		idxHi = 1'b0;
		indexMode = 2'h0;
		$display("index done");
		step(1'b0, 1'b0, 100);
		chk({svcBusy, |pending}, 2'h3);
		step(1'b1, 1'b0, 1400);
		expPos++;
		chk(posCount, expPos);
		step(1'b0, 1'b0, 1);
		settle();
		chk(posCount, expPos);
		$display("loss done");
		streamOn = 1'b1;
		tick(1);
		chk(streamHold, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			step(1'b1, 1'b0, 2499);
			expPos--;
		end
		settle();
		chk(posCount, expPos);
		streamOn = 1'b0;
		$display("stream done");
		// first line in service, other line queued, then replaced, then hit in its own service
		step(1'b0, 1'b0, 100);
		step(1'b0, 1'b0, 100);
		chk(pending, 2'h3);
		step(1'b1, 1'b0, 600);
		chk(svcBusy, 1'b1);
		step(1'b0, 1'b0, 1);
		settle();
		expPos++;
		chk(posCount, expPos);
		step(1'b1, 1'b0, 1);
		settle();
		chk(posCount, expPos);
		chk(errCount, expErr);
		$display("order done");
		test_done();
	end
endmodule
